// ---- core/psl_pkg.sv ----
// constants and register map of the checker, skew and loopback register bank
// ****************************************************************
// ****************************************************************
package psl_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] CHECKER_STATUS_TWO_OFFS     = 16'h0072;
  localparam logic [15:0] INTERFACE_SKEW_CONTROL_OFFS = 16'h0086;
  localparam logic [15:0] LOOPBACK_SETUP_OFFS         = 16'h00fe;
  localparam logic [15:0] CHECKER_BYTE_TALLY_OFFS     = 16'h0071;
  localparam logic [15:0] CHECKER_MODE_OFFS           = 16'h00f0;
  localparam logic [15:0] IRQ_STATUS_OFFS             = 16'h00f1;
  localparam logic [15:0] IRQ_ENABLE_OFFS             = 16'h00f2;
  localparam logic [15:0] IRQ_CLEAR_OFFS              = 16'h00f3;
  localparam int LOCK_BIT       = 0;
  localparam int LOCK_CLEAR_BIT = 1;
  localparam int PKT_OVF_BIT    = 10;
  localparam int BYTE_OVF_BIT   = 9;
  localparam int SKEW_W         = 4;
  localparam int TX_SKEW_LSB    = 4;
  localparam int RX_SKEW_LSB    = 0;
  localparam logic [3:0]  SKEW_RST      = 4'h7;
  localparam logic [15:0] LOOPBACK_RST  = 16'he721;
  localparam int ERR_W          = 8;
  localparam int BYTE_W         = 16;
  localparam int PKT_W          = 16;
  localparam int IRQ_W          = 3;
  localparam int IRQ_PKT_OVF    = 0;
  localparam int IRQ_BYTE_OVF   = 1;
  localparam int IRQ_ERR        = 2;
endpackage

// ---- core/psl_regs.sv ----
// register bank: checker status, interface skew control, loopback setup, interrupts
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module psl_regs (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic [psl_pkg::ADDR_W-1:0] addr,
  input  wire logic [psl_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output logic      [psl_pkg::DATA_W-1:0] rdata,
  input  wire logic                       chk_byte_evt,
  input  wire logic                       chk_err_evt,
  input  wire logic                       chk_pkt_evt,
  output logic      [psl_pkg::SKEW_W-1:0] tx_skew_code,
  output logic      [psl_pkg::SKEW_W-1:0] rx_skew_code,
  output logic      [psl_pkg::DATA_W-1:0] loopback_setup_word,
  output logic                            irq
);
  import psl_pkg::*;

  // ****************************************************************
  // write decode
  // ****************************************************************
  logic wr_status;
  logic do_lock;
  logic do_clear;
  assign wr_status = wr_stb && (addr == CHECKER_STATUS_TWO_OFFS);
  assign do_clear  = wr_status && wdata[LOCK_CLEAR_BIT];
  assign do_lock   = wr_status && (wdata[LOCK_BIT] || wdata[LOCK_CLEAR_BIT]);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [SKEW_W-1:0] tx_skew_reg;
  logic [SKEW_W-1:0] rx_skew_reg;
  logic [DATA_W-1:0] loop_reg;
  logic              checker_saturate_select_reg;
  logic [IRQ_W-1:0]  irq_en_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_skew_reg <= SKEW_RST;
      rx_skew_reg <= SKEW_RST;
    end else if (wr_stb && addr == INTERFACE_SKEW_CONTROL_OFFS) begin
      // upper byte dropped on write
      tx_skew_reg <= wdata[TX_SKEW_LSB +: SKEW_W];
      rx_skew_reg <= wdata[RX_SKEW_LSB +: SKEW_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loop_reg <= LOOPBACK_RST;
    end else if (wr_stb && addr == LOOPBACK_SETUP_OFFS) begin
      loop_reg <= wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      checker_saturate_select_reg <= 1'b0;
      irq_en_reg                  <= '0;
    end else if (wr_stb) begin
      if (addr == CHECKER_MODE_OFFS) begin
        checker_saturate_select_reg <= wdata[0];
      end
      if (addr == IRQ_ENABLE_OFFS) begin
        irq_en_reg <= wdata[IRQ_W-1:0];
      end
    end
  end

  // new codes reach the link one cycle after the write, no device reset needed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_skew_code        <= SKEW_RST;
      rx_skew_code        <= SKEW_RST;
      loopback_setup_word <= LOOPBACK_RST;
    end else begin
      tx_skew_code        <= tx_skew_reg;
      rx_skew_code        <= rx_skew_reg;
      loopback_setup_word <= loop_reg;
    end
  end

  // ****************************************************************
  // checker tallies
  // ****************************************************************
  logic             sat;
  logic [ERR_W-1:0] err_held;
  logic [BYTE_W-1:0] byte_held;
  logic             pkt_ovf;
  logic             byte_ovf;
  logic             err_ovf_evt;
  logic             byte_ovf_evt;
  logic             pkt_ovf_evt;
  assign sat = !checker_saturate_select_reg;

  psl_tally #(.W(ERR_W)) u_err (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inc      (chk_err_evt),
    .saturate (sat),
    .lock     (do_lock),
    .clear    (do_clear),
    .count    (),
    .held     (err_held),
    .ovf      (),
    .ovf_evt  (err_ovf_evt)
  );

  psl_tally #(.W(BYTE_W)) u_byte (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inc      (chk_byte_evt),
    .saturate (sat),
    .lock     (do_lock),
    .clear    (do_clear),
    .count    (),
    .held     (byte_held),
    .ovf      (byte_ovf),
    .ovf_evt  (byte_ovf_evt)
  );

  // packet counter always wraps so its overflow can be seen
  psl_tally #(.W(PKT_W)) u_pkt (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inc      (chk_pkt_evt),
    .saturate (1'b0),
    .lock     (do_lock),
    .clear    (do_clear),
    .count    (),
    .held     (),
    .ovf      (pkt_ovf),
    .ovf_evt  (pkt_ovf_evt)
  );

  // ****************************************************************
  // interrupts: set wins over clear
  // ****************************************************************
  logic [IRQ_W-1:0] irq_sts_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_set               = '0;
    irq_set[IRQ_PKT_OVF]  = pkt_ovf_evt;
    irq_set[IRQ_BYTE_OVF] = byte_ovf_evt;
    irq_set[IRQ_ERR]      = err_ovf_evt;
    irq_clr               = (wr_stb && addr == IRQ_CLEAR_OFFS) ? wdata[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_sts_reg <= '0;
    end else begin
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_sts_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [DATA_W-1:0] rd_next;
  always_comb begin
    rd_next = '0;
    case (addr)
      CHECKER_STATUS_TWO_OFFS: begin
        // reserved 15:11 and 8 stay zero
        rd_next[PKT_OVF_BIT]  = pkt_ovf;
        rd_next[BYTE_OVF_BIT] = byte_ovf;
        rd_next[ERR_W-1:0]    = err_held;
      end
      CHECKER_BYTE_TALLY_OFFS:     rd_next = byte_held;
      INTERFACE_SKEW_CONTROL_OFFS: rd_next = {8'h00, tx_skew_reg, rx_skew_reg};
      LOOPBACK_SETUP_OFFS:         rd_next = loop_reg;
      CHECKER_MODE_OFFS:           rd_next = {15'h0000, checker_saturate_select_reg};
      IRQ_STATUS_OFFS:             rd_next = {13'h0000, irq_sts_reg};
      IRQ_ENABLE_OFFS:             rd_next = {13'h0000, irq_en_reg};
      default:                     rd_next = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd_stb) begin
      rdata <= rd_next;
    end else begin
      rdata <= '0;
    end
  end
endmodule // psl_regs

// ---- core/psl_tally.sv ----
// saturating or wrapping event counter with overflow flag and readout lock
`timescale 1ns/10ps
module psl_tally #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         inc,
  input  wire logic         saturate,
  input  wire logic         lock,
  input  wire logic         clear,
  output logic [W-1:0]      count,
  output logic [W-1:0]      held,
  output logic              ovf,
  output logic              ovf_evt
);
  logic max_hit;
  assign max_hit = &count;
  assign ovf_evt = inc && max_hit && !clear;

  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      count <= '0;
    end else if (inc && !(saturate && max_hit)) begin
      count <= count + 1'b1;
    end
  end

  // overflow stays until a lock-and-clear
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      ovf <= 1'b0;
    end else if (ovf_evt) begin
      ovf <= 1'b1;
    end
  end

  // lock snapshots the live count before any clear applies
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      held <= '0;
    end else if (lock) begin
      held <= count;
    end
  end
endmodule // psl_tally

// ---- testbench/psl_evt_src.sv ----
// event source standing in for the sequence checker datapath
`timescale 1ns/10ps
module psl_evt_src (
  input  wire logic        sys_clk,
  input  wire logic        start,
  input  wire logic [17:0] n_evt,
  output logic             busy,
  output logic             evt
);
  // ****************************************************************
  // one pulse per cycle, back to back, to stress saturation
  // ****************************************************************
  logic [17:0] left_reg = 18'h00000;
  always_ff @(posedge sys_clk) begin
    if (start)
      left_reg <= n_evt;
    else if (busy)
      left_reg <= left_reg - 18'h00001;
  end
  assign busy = left_reg != 18'h00000;
  assign evt  = busy;
endmodule // psl_evt_src

// ---- testbench/psl_regs_checker.sv ----
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module psl_regs_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  input wire logic        chk_byte_evt,
  input wire logic        chk_pkt_evt,
  input wire logic [3:0]  tx_skew_code,
  input wire logic [3:0]  rx_skew_code,
  input wire logic [15:0] loopback_setup_word
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire       skw_w = wr_stb && addr == 16'h0086;
  wire       lbk_w = wr_stb && addr == 16'h00fe;
  wire       sts_w = wr_stb && addr == 16'h0072 && wdata[1];
  wire [3:0] tx_w  = wdata[7:4];
  property p_tx; skw_w |-> ##2 tx_skew_code == $past(tx_w, 2); endproperty
  a_tx: assert property (p_tx) else $error("tx skew code did not follow write");
  property p_hold; !skw_w |=> ##1 $stable({tx_skew_code, rx_skew_code}); endproperty
  a_hold: assert property (p_hold) else $error("skew codes moved without write");
  property p_lb; lbk_w |-> ##2 loopback_setup_word == $past(wdata, 2); endproperty
  a_lb: assert property (p_lb) else $error("loopback word did not follow write");
  property p_skhi; rd_stb && addr == 16'h0086 |=> rdata[15:8] == 8'h00; endproperty
  a_skhi: assert property (p_skhi) else $error("skew upper byte not zero");
  property p_rsv; rd_stb && addr == 16'h0072 |=> rdata[15:11] == 5'h00 && !rdata[8]; endproperty
  a_rsv: assert property (p_rsv) else $error("status reserved bits not zero");
  property p_idle; !rd_stb |=> rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_clr; sts_w ##[1:2] rd_stb && addr == 16'h0072 && !chk_byte_evt && !chk_pkt_evt |=> rdata[10:9] == 2'b00;
  endproperty
  a_clr: assert property (p_clr) else $error("overflow flags survived clear");
  property p_rbk; rd_stb && addr == 16'h0086 |=> rdata[7:0] == {tx_skew_code, rx_skew_code}; endproperty
  a_rbk: assert property (p_rbk) else $error("skew readback differs from codes");
endmodule // psl_regs_checker
bind psl_regs psl_regs_checker chk_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .chk_byte_evt(chk_byte_evt), .chk_pkt_evt(chk_pkt_evt),
  .tx_skew_code(tx_skew_code), .rx_skew_code(rx_skew_code), .loopback_setup_word(loopback_setup_word));

// ---- testbench/test_psl_regs.sv ----
// self-checking bench of the register bank
`timescale 1ns/10ps
module test_psl_regs;
  import psl_pkg::*;
  typedef struct {logic [15:0] a, d, e;} psl_row_s;
  logic sys_clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, start = 1'b0, busy, evt, irq;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, lb_word;
  logic [17:0] n_evt = 18'h00000;
  logic [3:0]  tx_skew_code, rx_skew_code;
  int          failures = 0, n_tests = 0;
  psl_row_s rows [6] = '{'{INTERFACE_SKEW_CONTROL_OFFS, 16'hffa3, 16'h00a3},
    '{INTERFACE_SKEW_CONTROL_OFFS, 16'h0000, 16'h0000}, '{INTERFACE_SKEW_CONTROL_OFFS, 16'h00ff, 16'h00ff},
    '{LOOPBACK_SETUP_OFFS, 16'h1234, 16'h1234}, '{16'h0050, 16'hffff, 16'h0000},
    '{CHECKER_STATUS_TWO_OFFS, 16'hfffc, 16'h0000}};
  psl_regs dut_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .chk_byte_evt(evt), .chk_err_evt(evt), .chk_pkt_evt(evt), .tx_skew_code(tx_skew_code),
    .rx_skew_code(rx_skew_code), .loopback_setup_word(lb_word), .irq(irq));
  psl_evt_src src_u (.sys_clk(sys_clk), .start(start), .n_evt(n_evt), .busy(busy), .evt(evt));
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic put(input logic [15:0] a, d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic get(input logic [15:0] a, e);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    chk("rdata", e, rdata);
  endtask
  // the task lets busy settle before polling it
  task automatic burst(input logic [17:0] n);
    @(posedge sys_clk);
    n_evt <= n;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
    for (int i = 0; busy && i < 70000; i++) @(negedge sys_clk);
  endtask
  task automatic complete_run;
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #1_000_000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      put(rows[i].a, rows[i].d);
      get(rows[i].a, rows[i].e);
      if (rows[i].a == INTERFACE_SKEW_CONTROL_OFFS) chk("skew", rows[i].e, {8'h00, tx_skew_code, rx_skew_code});
    end
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    get(INTERFACE_SKEW_CONTROL_OFFS, 16'h0077);
    get(LOOPBACK_SETUP_OFFS, LOOPBACK_RST);
    chk("lb_word", 16'he721, lb_word);
    get(CHECKER_STATUS_TWO_OFFS, 16'h0000);
    burst(18'h10000);
    chk("irq", 16'h0000, {15'h0000, irq});
    get(IRQ_STATUS_OFFS, 16'h0007);
    put(IRQ_ENABLE_OFFS, 16'h0007);
    get(IRQ_ENABLE_OFFS, 16'h0007);
    put(CHECKER_STATUS_TWO_OFFS, 16'h0001);
    get(CHECKER_STATUS_TWO_OFFS, 16'h06ff);
    get(CHECKER_BYTE_TALLY_OFFS, 16'hffff);
    chk("irq", 16'h0001, {15'h0000, irq});
    put(CHECKER_STATUS_TWO_OFFS, 16'h0002);
    get(CHECKER_STATUS_TWO_OFFS, 16'h00ff);
    put(CHECKER_STATUS_TWO_OFFS, 16'h0001);
    get(CHECKER_STATUS_TWO_OFFS, 16'h0000);
    get(CHECKER_BYTE_TALLY_OFFS, 16'h0000);
    put(IRQ_CLEAR_OFFS, 16'h0007);
    get(IRQ_STATUS_OFFS, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
    put(CHECKER_MODE_OFFS, 16'h0001);
    get(CHECKER_MODE_OFFS, 16'h0001);
    burst(18'h00101);
    get(IRQ_STATUS_OFFS, 16'h0004);
    chk("irq", 16'h0001, {15'h0000, irq});
    put(CHECKER_STATUS_TWO_OFFS, 16'h0001);
    get(CHECKER_STATUS_TWO_OFFS, 16'h0001);
    get(CHECKER_BYTE_TALLY_OFFS, 16'h0101);
    complete_run();
  end
endmodule // test_psl_regs
